// File: verilog/sfd_pkg.sv
// Constants, types and decode helpers for the serial receive framer/decoder
package sfd_pkg;

  localparam int CHAR_BITS = 10;
  localparam int STROBE_LOW_PCT = 60;
  localparam int APB_ADDR_W = 12;

  localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_RF_BIT = 0;
  localparam int CTRL_BYP_BIT = 1;
  localparam int ST_HUNT_BIT = 0;
  localparam int ST_RD_BIT = 1;
  localparam int ST_VIOL_BIT = 2;

  localparam logic [9:0] K285_NEG = 10'h0fa;
  localparam logic [9:0] K285_POS = 10'h305;
  localparam logic [5:0] SIX_K28_POS = 6'h30;
  localparam logic [5:0] SIX_D07_NEG = 6'h38;
  localparam logic [5:0] SIX_D07_POS = 6'h07;
  localparam logic [3:0] FOUR_NEUTRAL_NEG = 4'hc;
  localparam logic [3:0] FOUR_NEUTRAL_POS = 4'h3;
  localparam logic [7:0] CODE_UNASSIGNED = 8'he0;
  localparam logic [7:0] CODE_WRONG_RD = 8'he4;
  localparam logic [7:0] CODE_K23_7 = 8'h08;
  localparam logic [7:0] CODE_K27_7 = 8'h09;
  localparam logic [7:0] CODE_K29_7 = 8'h0a;
  localparam logic [7:0] CODE_K30_7 = 8'h0b;

  typedef struct packed {
    logic viol;
    logic spec;
    logic [7:0] data;
    logic rd;
  } sfd_dec_t;

  typedef struct packed {
    logic [9:0] shift;
    logic [3:0] bit_cnt;
    logic [9:0] dec;
    logic dec_vld;
    logic rd;
    logic [7:0] rx_byte;
    logic spec;
    logic viol;
    logic [9:0] raw;
    logic strobe_n;
    logic byte_clk;
    logic [3:0] phase;
    logic fire;
    logic reframe;
    logic hunting;
    logic ctrl_rf;
    logic ctrl_byp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sfd_state_t;

  function automatic logic [2:0] sfd_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction : sfd_ones

endpackage : sfd_pkg

// File: verilog/sfd_rx_framer.sv
// Receive framer, 8B/10B decoder, strobe generator and APB control slave
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module sfd_rx_framer
  import sfd_pkg::*;
#(
  parameter int CHAR_PERIOD = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_en,
  input wire logic serial_bit,
  output logic [7:0] rx_byte,
  output logic special_char_flag,
  output logic violation_flag,
  output logic [9:0] rx_raw_char,
  output logic rx_strobe_n,
  output logic recovered_byte_clock
);

  generate
    if (CHAR_PERIOD != CHAR_BITS) begin : g_bad_period
      $error("sfd_rx_framer: CHAR_PERIOD must equal the character width");
    end
  endgenerate

  localparam logic [3:0] LAST_BIT = 4'(CHAR_PERIOD - 1);
  localparam logic [3:0] LOW_BITS = 4'(CHAR_PERIOD * STROBE_LOW_PCT / 100);

  // The strobe needs both a low and a high part inside one character
  generate
    if ((LOW_BITS == 4'h0) || (LOW_BITS >= LAST_BIT)) begin : g_bad_low
      $error("sfd_rx_framer: strobe low span does not fit a character");
    end
  endgenerate

  // Full 8B/10B character decode with running disparity check
  function automatic sfd_dec_t sfd_decode(input logic [9:0] c,
                                          input logic rd_in);
    sfd_dec_t r;
    logic [5:0] six;
    logic [3:0] four;
    logic [3:0] f4;
    logic [4:0] d5;
    logic [2:0] d3;
    logic bad;
    logic ok;
    logic k28;
    logic a7;
    logic rd1;
    logic [2:0] n6;
    logic [2:0] n4;
    six = c[9:4];
    four = c[3:0];
    bad = 1'b0;
    ok = 1'b1;
    k28 = 1'b0;
    d5 = 5'h00;
    d3 = 3'h0;
    a7 = 1'b0;
    rd1 = rd_in;
    r = '0;
    unique case (six)
      6'b100111, 6'b011000: d5 = 5'd0;
      6'b011101, 6'b100010: d5 = 5'd1;
      6'b101101, 6'b010010: d5 = 5'd2;
      6'b110001: d5 = 5'd3;
      6'b110101, 6'b001010: d5 = 5'd4;
      6'b101001: d5 = 5'd5;
      6'b011001: d5 = 5'd6;
      6'b111000, 6'b000111: d5 = 5'd7;
      6'b111001, 6'b000110: d5 = 5'd8;
      6'b100101: d5 = 5'd9;
      6'b010101: d5 = 5'd10;
      6'b110100: d5 = 5'd11;
      6'b001101: d5 = 5'd12;
      6'b101100: d5 = 5'd13;
      6'b011100: d5 = 5'd14;
      6'b010111, 6'b101000: d5 = 5'd15;
      6'b011011, 6'b100100: d5 = 5'd16;
      6'b100011: d5 = 5'd17;
      6'b010011: d5 = 5'd18;
      6'b110010: d5 = 5'd19;
      6'b001011: d5 = 5'd20;
      6'b101010: d5 = 5'd21;
      6'b011010: d5 = 5'd22;
      6'b111010, 6'b000101: d5 = 5'd23;
      6'b110011, 6'b001100: d5 = 5'd24;
      6'b100110: d5 = 5'd25;
      6'b010110: d5 = 5'd26;
      6'b110110, 6'b001001: d5 = 5'd27;
      6'b001110: d5 = 5'd28;
      6'b101110, 6'b010001: d5 = 5'd29;
      6'b011110, 6'b100001: d5 = 5'd30;
      6'b101011, 6'b010100: d5 = 5'd31;
      6'b001111, 6'b110000: k28 = 1'b1;
      default: bad = 1'b1;
    endcase
    // K28 in positive disparity carries an inverted 4b group
    f4 = (six == SIX_K28_POS) ? ~four : four;
    unique case (f4)
      4'b1011, 4'b0100: d3 = 3'd0;
      4'b1001: d3 = 3'd1;
      4'b0101: d3 = 3'd2;
      4'b1100, 4'b0011: d3 = 3'd3;
      4'b1101, 4'b0010: d3 = 3'd4;
      4'b1010: d3 = 3'd5;
      4'b0110: d3 = 3'd6;
      4'b1110, 4'b0001: d3 = 3'd7;
      4'b0111, 4'b1000: begin
        d3 = 3'd7;
        a7 = 1'b1;
      end
      default: bad = 1'b1;
    endcase
    n6 = sfd_ones(six);
    n4 = sfd_ones({2'b00, four});
    // Each sub-block must suit the disparity it arrives with
    if (n6 == 3'd4) begin
      ok = ~rd_in;
      rd1 = 1'b1;
    end else if (n6 == 3'd2) begin
      ok = rd_in;
      rd1 = 1'b0;
    end else if (n6 == 3'd3) begin
      if (six == SIX_D07_NEG) begin
        ok = ~rd_in;
      end else if (six == SIX_D07_POS) begin
        ok = rd_in;
      end
    end else begin
      bad = 1'b1;
    end
    r.rd = rd1;
    if (n4 == 3'd3) begin
      ok = ok & ~rd1;
      r.rd = 1'b1;
    end else if (n4 == 3'd1) begin
      ok = ok & rd1;
      r.rd = 1'b0;
    end else if (n4 == 3'd2) begin
      if (four == FOUR_NEUTRAL_NEG) begin
        ok = ok & ~rd1;
      end else if (four == FOUR_NEUTRAL_POS) begin
        ok = ok & rd1;
      end
    end else begin
      bad = 1'b1;
    end
    if (k28) begin
      r.spec = 1'b1;
      r.data = {5'h00, d3};
    end else if (a7 && (d5 == 5'd23)) begin
      r.spec = 1'b1;
      r.data = CODE_K23_7;
    end else if (a7 && (d5 == 5'd27)) begin
      r.spec = 1'b1;
      r.data = CODE_K27_7;
    end else if (a7 && (d5 == 5'd29)) begin
      r.spec = 1'b1;
      r.data = CODE_K29_7;
    end else if (a7 && (d5 == 5'd30)) begin
      r.spec = 1'b1;
      r.data = CODE_K30_7;
    end else begin
      r.spec = 1'b0;
      r.data = {d3, d5};
    end
    // A sent violation is just another unassigned code here
    if (bad) begin
      r.viol = 1'b1;
      r.spec = 1'b1;
      r.data = CODE_UNASSIGNED;
    end else if (!ok) begin
      r.viol = 1'b1;
      r.spec = 1'b1;
      r.data = CODE_WRONG_RD;
    end
    return r;
  endfunction : sfd_decode

  function automatic logic sfd_is_comma(input logic [9:0] c);
    return (c == K285_NEG) || (c == K285_POS);
  endfunction : sfd_is_comma

  sfd_state_t s_q;
  sfd_state_t s_d;

  logic [9:0] win;
  logic comma;
  logic char_done;
  logic fire_new;
  logic acc;
  logic [3:0] phase_n;
  sfd_dec_t dr;

  always_comb begin
    s_d = s_q;
    win = {s_q.shift[8:0], serial_bit};
    comma = sfd_is_comma(win);
    dr = sfd_decode(s_q.dec, s_q.rd);
    fire_new = 1'b0;
    phase_n = s_q.phase;
    acc = psel & penable;
    // Boundary at the tenth bit, or at once on a comma when allowed
    char_done = bit_en & ((s_q.bit_cnt == LAST_BIT)
                          | (comma & s_q.reframe));

    if (bit_en) begin
      s_d.shift = win;
      s_d.bit_cnt = s_q.bit_cnt + 4'h1;
    end

    if (char_done) begin
      s_d.bit_cnt = 4'h0;
      s_d.dec = win;
      s_d.dec_vld = 1'b1;
      // Outputs update together at the byte clock fall
      // The empty decode register after reset is never shown, so the
      // outputs keep their reset values until a real character lands
      if (s_q.dec_vld) begin
        s_d.raw = s_q.dec;
        if (s_q.ctrl_byp) begin
          // Encoded fields park at zero in bypass
          s_d.rx_byte = 8'h00;
          s_d.spec = 1'b0;
          s_d.viol = 1'b0;
        end else begin
          s_d.rx_byte = dr.data;
          s_d.spec = dr.spec;
          s_d.viol = dr.viol;
          s_d.rd = dr.rd;
        end
      end
      if (!s_q.dec_vld) begin
        fire_new = 1'b0;
      end else if (s_q.hunting) begin
        // Framed comma reaching the output ends the search
        fire_new = sfd_is_comma(s_q.dec);
        if (sfd_is_comma(s_q.dec)) begin
          s_d.hunting = 1'b0;
        end
      end else if (s_q.ctrl_byp) begin
        // Raw mode with framer on marks only commas
        fire_new = s_q.reframe ? sfd_is_comma(s_q.dec) : 1'b1;
      end else begin
        // Comma then comma is fill; anything else after it counts
        fire_new = ~(sfd_is_comma(s_q.dec) & comma);
      end
      // Reframe enable taken as the byte clock falls
      s_d.reframe = s_q.ctrl_rf;
      if (s_q.ctrl_rf && !s_q.reframe) begin
        s_d.hunting = 1'b1;
      end
      if (!s_q.ctrl_rf) begin
        s_d.hunting = 1'b0;
      end
      s_d.fire = fire_new;
      phase_n = 4'h0;
    end else if (bit_en && (s_q.phase != LAST_BIT)) begin
      phase_n = s_q.phase + 4'h1;
    end
    s_d.phase = phase_n;
    // Low for the first 60% of the character when firing
    s_d.strobe_n = ~(s_d.fire & (phase_n < LOW_BITS));
    s_d.byte_clk = (phase_n >= LOW_BITS);

    // APB: one wait state, writes land on the completing edge
    s_d.pready = acc & ~s_q.pready;
    // Error is a one-cycle answer, it must not outlive pready
    s_d.pslverr = 1'b0;
    if (acc && !s_q.pready) begin
      s_d.pslverr = (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS);
      s_d.prdata = 32'h0000_0000;
      if (!pwrite && (paddr == ADDR_CTRL)) begin
        s_d.prdata[CTRL_RF_BIT] = s_q.ctrl_rf;
        s_d.prdata[CTRL_BYP_BIT] = s_q.ctrl_byp;
      end else if (!pwrite && (paddr == ADDR_STATUS)) begin
        s_d.prdata[ST_HUNT_BIT] = s_q.hunting;
        s_d.prdata[ST_RD_BIT] = s_q.rd;
        s_d.prdata[ST_VIOL_BIT] = s_q.viol;
      end
    end
    if (acc && s_q.pready && pwrite && (paddr == ADDR_CTRL)) begin
      s_d.ctrl_rf = pwdata[CTRL_RF_BIT];
      s_d.ctrl_byp = pwdata[CTRL_BYP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.strobe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Receiver should gate capture with the strobe
  assign rx_strobe_n = s_q.strobe_n;
  assign recovered_byte_clock = s_q.byte_clk;
  assign rx_byte = s_q.rx_byte;
  assign special_char_flag = s_q.spec;
  assign violation_flag = s_q.viol;
  assign rx_raw_char = s_q.raw;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule : sfd_rx_framer

// File: verif/sfd_rx_framer_assertions.sv
// Port checker for the receive framer, bound to its top module
`timescale 1ns/10ps
module sfd_rx_framer_chk
  import sfd_pkg::*;
#(
  parameter int CHAR_PERIOD = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_en,
  input wire logic serial_bit,
  input wire logic [7:0] rx_byte,
  input wire logic special_char_flag,
  input wire logic violation_flag,
  input wire logic [9:0] rx_raw_char,
  input wire logic rx_strobe_n,
  input wire logic recovered_byte_clock
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Six low cycles assume one bit time per clock
  sequence s_low6;
    !rx_strobe_n [*6] ##1 rx_strobe_n;
  endsequence
  sequence s_acc;
    psel && $rose(penable);
  endsequence
  strobe_low_a: assert property ($fell(rx_strobe_n) |-> s_low6)
    else $error("strobe low span wrong");
  strobe_rise_a: assert property (
    $rose(rx_strobe_n) |-> $rose(recovered_byte_clock))
    else $error("strobe rise off the byte clock");
  strobe_clock_a: assert property (
    $fell(rx_strobe_n) |-> !recovered_byte_clock)
    else $error("strobe falls in high clock phase");
  out_together_a: assert property (
    $changed(rx_byte) || $changed(special_char_flag)
    |-> $changed(rx_raw_char) && !recovered_byte_clock)
    else $error("outputs change apart");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_wait_a: assert property (s_acc |=> pready)
    else $error("pready not one cycle after access");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_zero_a: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response not clean");
  viol_spec_a: assert property (
    violation_flag |-> special_char_flag)
    else $error("violation without special flag");
endmodule : sfd_rx_framer_chk

bind sfd_rx_framer sfd_rx_framer_chk #(.CHAR_PERIOD(CHAR_PERIOD)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bit_en(bit_en),
  .serial_bit(serial_bit), .rx_byte(rx_byte),
  .special_char_flag(special_char_flag), .violation_flag(violation_flag),
  .rx_raw_char(rx_raw_char), .rx_strobe_n(rx_strobe_n),
  .recovered_byte_clock(recovered_byte_clock));

// File: verif/sfd_tx_model.sv
// Remote transmitter model: serial characters, comma fill while idle
`timescale 1ns/10ps
module sfd_tx_model
  import sfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  output logic bit_en,
  output logic serial_bit
);
  logic bits_q[$];
  logic rd_pos_q;
  task automatic push(input logic [9:0] c);
    for (int i = 9; i >= 0; i--) begin
      bits_q.push_back(c[i]);
    end
    if ($countones(c) != 5) begin
      rd_pos_q = !rd_pos_q;
    end
  endtask : push
  task automatic send(input logic [9:0] neg, input logic [9:0] pos);
    push(rd_pos_q ? pos : neg);
  endtask : send
  // Stray bits knock the boundary off by n
  task automatic slip(input int n);
    for (int i = 0; i < n; i++) begin
      bits_q.push_back(i[0]);
    end
  endtask : slip
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_q.delete();
      rd_pos_q = 1'b0;
      bit_en <= 1'b0;
      serial_bit <= 1'b0;
    end else begin
      if (bits_q.size() == 0) begin
        send(K285_NEG, K285_POS); // Idle link carries fill
      end
      bit_en <= 1'b1;
      serial_bit <= bits_q.pop_front();
    end
  end
endmodule : sfd_tx_model

// File: verif/test_sfd_rx_framer.sv
// Self-checking bench for the receive framer and decoder
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sfd_rx_framer import sfd_pkg::*;;
  typedef struct packed {
    logic [9:0] neg;
    logic [9:0] pos;
    logic [7:0] b;
    logic s;
  } sfd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic bit_en, serial_bit, spec, viol, stb_n, bclk, stb_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_byte;
  logic [9:0] raw;
  logic [19:0] seen[$];
  int bad_count, checks_done, base, idx;
  // Row 0 is the last fill comma, which strobes ahead of row 1
  sfd_row_t rows[7] = '{
    '{10'h0fa, 10'h305, 8'h05, 1'b1}, '{10'h0f4, 10'h30b, 8'h00, 1'b1},
    '{10'h274, 10'h18b, 8'h00, 1'b0}, '{10'h2aa, 10'h2aa, 8'hb5, 1'b0},
    '{10'h0fa, 10'h305, 8'h05, 1'b1}, '{10'h3a8, 10'h057, 8'h08, 1'b1},
    '{10'h274, 10'h18b, 8'h00, 1'b0}};
  sfd_rx_framer #(.CHAR_PERIOD(10)) sfd_rx_framer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_en(bit_en),
    .serial_bit(serial_bit), .rx_byte(rx_byte), .special_char_flag(spec),
    .violation_flag(viol), .rx_raw_char(raw), .rx_strobe_n(stb_n),
    .recovered_byte_clock(bclk));
  sfd_tx_model sfd_tx_model_i (.pclk(pclk), .presetn(presetn),
    .bit_en(bit_en), .serial_bit(serial_bit));
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (stb_q === 1'b1 && stb_n === 1'b0) begin
      seen.push_back({viol, spec, rx_byte, raw});
    end
    stb_q <= stb_n;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_seen(input int n);
    for (int k = 0; k < 3000 && seen.size() < n; k++) @(posedge pclk);
  endtask : wait_seen
  task automatic find(input logic [9:0] c);
    idx = -1;
    for (int j = base; j < seen.size(); j++) if (seen[j][9:0] === c) idx = j;
  endtask : find
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
  endtask : do_reset
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, stb_q} = '0;
    do_reset();
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    `CHK("ctrl_reset", 32'h0000_0000, rd)
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("hunting", 1'b0, rd[ST_HUNT_BIT])
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, err)
    base = seen.size();
    for (int i = 1; i < 7; i++) sfd_tx_model_i.send(rows[i].neg, rows[i].pos);
    wait_seen(base + 7);
    for (int i = 0; i < 7; i++) begin
      `CHK("byte", rows[i].b, seen[base+i][17:10])
      `CHK("spec", rows[i].s, seen[base+i][18])
      `CHK("viol", 1'b0, seen[base+i][19])
    end
    base = seen.size();
    sfd_tx_model_i.push(sfd_tx_model_i.rd_pos_q ? 10'h274 : 10'h18b);
    sfd_tx_model_i.push(10'h3e0);
    wait_seen(base + 3);
    `CHK("wrong_rd", {2'b11, 8'he4}, seen[base+1][19:10])
    `CHK("unassigned", {2'b11, 8'he0}, seen[base+2][19:10])
    repeat (60) @(posedge pclk);
    base = seen.size();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    wait_seen(base + 1);
    find(seen[base][9:0]);
    `CHK("hunt_comma", 1'b1, raw_is_comma(seen[base][9:0]))
    base = seen.size();
    sfd_tx_model_i.slip(7);
    sfd_tx_model_i.send(K285_NEG, K285_POS);
    sfd_tx_model_i.send(10'h2aa, 10'h2aa);
    repeat (200) @(posedge pclk);
    find(10'h2aa);
    `CHK("realign", 8'hb5, idx >= 0 ? seen[idx][17:10] : 8'hxx)
    do_reset();
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    repeat (30) @(posedge pclk);
    base = seen.size();
    sfd_tx_model_i.send(10'h2aa, 10'h2aa);
    repeat (100) @(posedge pclk);
    find(10'h2aa);
    `CHK("bypass", 9'h000, idx >= 0 ? seen[idx][18:10] : 9'h1ff)
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    base = seen.size();
    sfd_tx_model_i.send(10'h2aa, 10'h2aa);
    repeat (200) @(posedge pclk);
    `CHK("byp_pulses", 1'b1, seen.size() > base + 10)
    for (int j = base; j < seen.size(); j++)
      `CHK("byp_comma", 1'b1, raw_is_comma(seen[j][9:0]))
    close_out();
  end
  function automatic logic raw_is_comma(input logic [9:0] c);
    return c === K285_NEG || c === K285_POS;
  endfunction : raw_is_comma
endmodule : test_sfd_rx_framer
